// *** hw/mhl_pkg.sv ***
// Package for the meter host link control block.
// Assumes a 20 MHz core clock and a 32-bit register port.
package mhl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int RX_TIMEOUT_MS    = 10;         // Nominal receive time-out
  localparam int RX_TIMEOUT_MAX_MS = 20;        // Latest allowed abandon
  localparam int RX_TIMEOUT_CYC   = (RX_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BAUD_DIV_SLOW    = 2083;       // Bit period in cycles, rate pin low
  localparam int BAUD_DIV_FAST    = 520;        // Bit period in cycles, rate pin high
  localparam int CMD_BYTES        = 4;          // Bytes per host command
  localparam int DIV_W            = 16;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG  = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_TXDATA  = 8'h08;
  localparam logic [7:0] ADDR_RXCMD   = 8'h0c;
  localparam logic [7:0] ADDR_GIO_DIR = 8'h10;
  localparam logic [7:0] ADDR_GIO_OUT = 8'h14;
  localparam logic [7:0] ADDR_GIO_IN  = 8'h18;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CFG_EQU_LSB   = 5;             // Equation select in bits 7..5
  localparam int CFG_EQU_MSB   = 7;
  localparam int CFG_IRQ_EN    = 0;             // Data-ready pin enable
  localparam logic [31:0] CFG_RESET = 32'h0000_00a1; // Equation 5, pin enabled

  localparam int ST_READY      = 0;
  localparam int ST_UNINIT     = 1;
  localparam int ST_TX_BUSY    = 2;
  localparam int ST_CMD_VALID  = 3;

  // Equation codes
  localparam logic [2:0] EQU_STAR_4W   = 3'h5;
  localparam logic [2:0] EQU_GND_3W    = 3'h2;
  localparam logic [2:0] EQU_DELTA_4W  = 3'h3;

  localparam int GIO_W = 8;

endpackage

// *** hw/mhl_top.sv ***
// Host link control of the metering device: UART command receiver
// with desync time-out, data-ready pin, strap capture, link purge,
// equation select and eight general-purpose pins.
// Assumes all pins are synchronous to clk; the metering core pulses
// data_fresh and reads metering_equation_select.
//
// Summary of operation
// - Equation select lives in config bits 7..5
// - Code 3 selects four-wire delta equation
// - Data-ready pin driven low on fresh data
// - Low hardware reset pin resets whole device
// - Low purge pin empties UART buffers
// - Rate and pulse polarity taken from strap pins
// - Partial command dropped after 10 ms idle
// - Time-out sets the uninitialised flag
// - Eight general-purpose pins for host use
// - Uninitialised flag held in status register
// - Purge restores UART defaults, metering untouched
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module mhl_top #(
  parameter int RX_TIMEOUT_CYC = mhl_pkg::RX_TIMEOUT_CYC,
  parameter int BAUD_DIV_SLOW  = mhl_pkg::BAUD_DIV_SLOW,
  parameter int BAUD_DIV_FAST  = mhl_pkg::BAUD_DIV_FAST,
  parameter int CMD_BYTES      = mhl_pkg::CMD_BYTES
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire logic                     hw_reset_n,
  input  wire logic                     link_purge_n,
  input  wire logic                     baud_sel,
  input  wire logic                     pulse_init,
  input  wire logic                     rx,
  output logic                          tx,
  output logic                          data_ready_n,
  input  wire logic                     data_fresh,
  output logic [2:0]                    metering_equation_select,
  output logic                          pulse_polarity,
  output logic                          cmd_valid,
  output logic [8*CMD_BYTES-1:0]        cmd_data,
  input  wire logic [mhl_pkg::GIO_W-1:0] general_io_pin_i,
  output logic [mhl_pkg::GIO_W-1:0]     general_io_pin_o,
  output logic [mhl_pkg::GIO_W-1:0]     general_io_pin_oe,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata
);

  localparam int TO_W  = $clog2(RX_TIMEOUT_CYC + 1);
  localparam int CNT_W = $clog2(CMD_BYTES + 1);
  localparam int DIV_W = mhl_pkg::DIV_W;

  // ----------------------------------------------------------------
  // Device reset
  // ----------------------------------------------------------------
  // The pin is taken as synchronous, so it folds into the core reset
  logic dev_rst;
  assign dev_rst = rst | ~hw_reset_n;

  // Purge only reaches link state, never the metering configuration
  logic purge;
  assign purge = ~link_purge_n;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic strap_load_r, strap_load_nxt;
  logic baud_fast_r, baud_fast_nxt;
  logic pol_r, pol_nxt;

  // Both straps are sampled in the cycle after reset release, the rate strap again on
  // every purge, so the host can change the rate only through a purge or a reset
  always_comb begin
    strap_load_nxt = 1'b0;
    baud_fast_nxt  = baud_fast_r;
    pol_nxt        = pol_r;
    if (strap_load_r || purge) begin
      baud_fast_nxt = baud_sel;
    end
    if (strap_load_r) begin
      pol_nxt = pulse_init;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      strap_load_r <= 1'b1;
      baud_fast_r  <= 1'b0;
      pol_r        <= 1'b0;
    end else if (clk_en) begin
      strap_load_r <= strap_load_nxt;
      baud_fast_r  <= baud_fast_nxt;
      pol_r        <= pol_nxt;
    end
  end

  logic [DIV_W-1:0] baud_div;
  assign baud_div = baud_fast_r ? DIV_W'(BAUD_DIV_FAST) : DIV_W'(BAUD_DIV_SLOW);
  assign pulse_polarity = pol_r;

  // ----------------------------------------------------------------
  // UART engines
  // ----------------------------------------------------------------
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       tx_start;
  logic [7:0] tx_byte;
  logic       tx_busy;

  mhl_uart_rx #(.DIV_W(DIV_W)) u_rx (
    .clk        (clk),
    .rst        (dev_rst),
    .clk_en     (clk_en),
    .clr        (purge),
    .div        (baud_div),
    .rx         (rx),
    .byte_valid (rx_valid),
    .byte_data  (rx_byte)
  );

  mhl_uart_tx #(.DIV_W(DIV_W)) u_tx (
    .clk    (clk),
    .rst    (dev_rst),
    .clk_en (clk_en),
    .clr    (purge),
    .div    (baud_div),
    .start  (tx_start),
    .data   (tx_byte),
    .tx     (tx),
    .busy   (tx_busy)
  );

  // ----------------------------------------------------------------
  // Command assembly and desync time-out
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]         nbytes_r, nbytes_nxt;
  logic [8*CMD_BYTES-1:0]   asm_r, asm_nxt;
  logic [TO_W-1:0]          idle_r, idle_nxt;
  logic                     cmd_valid_r, cmd_valid_nxt;
  logic [8*CMD_BYTES-1:0]   cmd_r, cmd_nxt;
  logic                     timeout;

  // Idle counter only runs inside a partial command; an extra byte from
  // the host shifts framing, and only the time-out or a purge brings it back
  always_comb begin
    nbytes_nxt    = nbytes_r;
    asm_nxt       = asm_r;
    idle_nxt      = idle_r;
    cmd_valid_nxt = 1'b0;
    cmd_nxt       = cmd_r;
    timeout       = 1'b0;
    if (rx_valid) begin
      asm_nxt  = {asm_r[8*CMD_BYTES-9:0], rx_byte};
      idle_nxt = '0;
      if (nbytes_r == CNT_W'(CMD_BYTES - 1)) begin
        nbytes_nxt    = '0;
        cmd_valid_nxt = 1'b1;
        cmd_nxt       = {asm_r[8*CMD_BYTES-9:0], rx_byte};
      end else begin
        nbytes_nxt = nbytes_r + 1'b1;
      end
    end else if (nbytes_r != '0) begin
      if (idle_r == TO_W'(RX_TIMEOUT_CYC - 1)) begin
        timeout    = 1'b1;
        nbytes_nxt = '0;
        idle_nxt   = '0;
      end else begin
        idle_nxt = idle_r + 1'b1;
      end
    end
    if (purge) begin
      nbytes_nxt    = '0;
      idle_nxt      = '0;
      cmd_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      nbytes_r    <= '0;
      asm_r       <= '0;
      idle_r      <= '0;
      cmd_valid_r <= 1'b0;
      cmd_r       <= '0;
    end else if (clk_en) begin
      nbytes_r    <= nbytes_nxt;
      asm_r       <= asm_nxt;
      idle_r      <= idle_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      cmd_r       <= cmd_nxt;
    end
  end

  assign cmd_valid = cmd_valid_r;
  assign cmd_data  = cmd_r;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]               cfg_r, cfg_nxt;
  logic                      ready_r, ready_nxt;
  logic                      uninit_r, uninit_nxt;
  logic                      cmd_sticky_r, cmd_sticky_nxt;
  logic [mhl_pkg::GIO_W-1:0] gdir_r, gdir_nxt;
  logic [mhl_pkg::GIO_W-1:0] gout_r, gout_nxt;
  logic [31:0]               rdata_r, rdata_nxt;
  logic                      wr_st, wr_tx;
  logic [31:0]               status;

  assign wr_st    = reg_wr && (reg_addr == mhl_pkg::ADDR_STATUS);
  assign wr_tx    = reg_wr && (reg_addr == mhl_pkg::ADDR_TXDATA);
  assign tx_start = wr_tx && !tx_busy; // Writes while busy are dropped
  assign tx_byte  = reg_wdata[7:0];

  always_comb begin
    status = 32'h0000_0000;
    status[mhl_pkg::ST_READY]     = ready_r;
    status[mhl_pkg::ST_UNINIT]    = uninit_r;
    status[mhl_pkg::ST_TX_BUSY]   = tx_busy;
    status[mhl_pkg::ST_CMD_VALID] = cmd_sticky_r;
  end

  // Status flags are write-one-to-clear; a hardware set in the same
  // cycle as the clear wins so no event is lost
  always_comb begin
    cfg_nxt        = cfg_r;
    gdir_nxt       = gdir_r;
    gout_nxt       = gout_r;
    ready_nxt      = ready_r;
    uninit_nxt     = uninit_r;
    cmd_sticky_nxt = cmd_sticky_r;
    if (reg_wr) begin
      unique case (reg_addr)
        mhl_pkg::ADDR_CONFIG:  cfg_nxt  = reg_wdata;
        mhl_pkg::ADDR_GIO_DIR: gdir_nxt = reg_wdata[mhl_pkg::GIO_W-1:0];
        mhl_pkg::ADDR_GIO_OUT: gout_nxt = reg_wdata[mhl_pkg::GIO_W-1:0];
        default: ;
      endcase
    end
    if (wr_st) begin
      if (reg_wdata[mhl_pkg::ST_READY]) ready_nxt = 1'b0;
      if (reg_wdata[mhl_pkg::ST_UNINIT]) uninit_nxt = 1'b0;
      if (reg_wdata[mhl_pkg::ST_CMD_VALID]) cmd_sticky_nxt = 1'b0;
    end
    if (data_fresh) ready_nxt = 1'b1;
    if (timeout) uninit_nxt = 1'b1;
    if (cmd_valid_r) cmd_sticky_nxt = 1'b1;
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        mhl_pkg::ADDR_CONFIG:  rdata_nxt = cfg_r;
        mhl_pkg::ADDR_STATUS:  rdata_nxt = status;
        mhl_pkg::ADDR_RXCMD:   rdata_nxt = 32'(cmd_r);
        mhl_pkg::ADDR_GIO_DIR: rdata_nxt = {24'h000000, gdir_r};
        mhl_pkg::ADDR_GIO_OUT: rdata_nxt = {24'h000000, gout_r};
        mhl_pkg::ADDR_GIO_IN:  rdata_nxt = {24'h000000, general_io_pin_i};
        default:               rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Configuration is reset only by the device reset, never by purge
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      cfg_r        <= mhl_pkg::CFG_RESET;
      ready_r      <= 1'b0;
      uninit_r     <= 1'b1;              // Flag stands after every reset
      cmd_sticky_r <= 1'b0;
      gdir_r       <= 8'h00;
      gout_r       <= 8'h00;
      rdata_r      <= 32'h0000_0000;
    end else if (clk_en) begin
      cfg_r        <= cfg_nxt;
      ready_r      <= ready_nxt;
      uninit_r     <= uninit_nxt;
      cmd_sticky_r <= cmd_sticky_nxt;
      gdir_r       <= gdir_nxt;
      gout_r       <= gout_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Outputs to pins and metering core
  // ----------------------------------------------------------------
  // Field passes straight to the core; codes 5, 2 and 3 pick the star,
  // grounded three-wire and four-wire delta equations
  assign metering_equation_select =
    cfg_r[mhl_pkg::CFG_EQU_MSB:mhl_pkg::CFG_EQU_LSB];

  // Pin follows the sticky ready flag, so the host sees every data set
  assign data_ready_n = ~(ready_r & cfg_r[mhl_pkg::CFG_IRQ_EN]);

  assign general_io_pin_o  = gout_r;
  assign general_io_pin_oe = gdir_r;

endmodule // mhl_top

// *** hw/mhl_uart_rx.sv ***
// UART receiver, 8 data bits, no parity, one stop bit.
// Assumes rx is synchronous to clk; clr purges any byte in flight.
`timescale 1ns/10ps
module mhl_uart_rx #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             clr,
  input  wire logic [DIV_W-1:0] div,
  input  wire logic             rx,
  output logic                  byte_valid,
  output logic [7:0]            byte_data
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mhl_rx_e;

  mhl_rx_e          state_r, state_nxt;
  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic [2:0]       bit_r, bit_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic             val_r, val_nxt;

  // ----------------------------------------------------------------
  // Bit timing, sampled mid-bit
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    val_nxt   = 1'b0;
    unique case (state_r)
      RX_IDLE: begin
        if (!rx) begin
          state_nxt = RX_START;
          cnt_nxt   = div >> 1;             // Land in the middle of start bit
        end
      end
      RX_START: begin
        if (cnt_r == '0) begin
          // A glitch shorter than half a bit is dropped
          state_nxt = rx ? RX_IDLE : RX_DATA;
          cnt_nxt   = div - 1'b1;
          bit_nxt   = 3'h0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      RX_DATA: begin
        if (cnt_r == '0) begin
          sh_nxt  = {rx, sh_r[7:1]};        // LSB first
          cnt_nxt = div - 1'b1;
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            state_nxt = RX_STOP;
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      RX_STOP: begin
        if (cnt_r == '0) begin
          state_nxt = RX_IDLE;
          val_nxt   = rx;                   // Framing error drops the byte
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
    endcase
    if (clr) begin
      state_nxt = RX_IDLE;
      val_nxt   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= RX_IDLE;
      cnt_r   <= '0;
      bit_r   <= 3'h0;
      sh_r    <= 8'h00;
      val_r   <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      val_r   <= val_nxt;
    end
  end

  assign byte_valid = val_r & clk_en;
  assign byte_data  = sh_r;

endmodule // mhl_uart_rx

// *** hw/mhl_uart_tx.sv ***
// UART transmitter, 8N1, one byte at a time.
// Assumes start is only raised while busy is low.
`timescale 1ns/10ps
module mhl_uart_tx #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             clr,
  input  wire logic [DIV_W-1:0] div,
  input  wire logic             start,
  input  wire logic [7:0]       data,
  output logic                  tx,
  output logic                  busy
);

  logic [9:0]       sh_r, sh_nxt;
  logic [3:0]       left_r, left_nxt;
  logic [DIV_W-1:0] cnt_r, cnt_nxt;

  // ----------------------------------------------------------------
  // Shift out start, data, stop
  // ----------------------------------------------------------------
  always_comb begin
    sh_nxt   = sh_r;
    left_nxt = left_r;
    cnt_nxt  = cnt_r;
    if (left_r == 4'h0) begin
      if (start) begin
        sh_nxt   = {1'b1, data, 1'b0};
        left_nxt = 4'ha;
        cnt_nxt  = div - 1'b1;
      end
    end else if (cnt_r == '0) begin
      sh_nxt   = {1'b1, sh_r[9:1]};
      left_nxt = left_r - 4'h1;
      cnt_nxt  = div - 1'b1;
    end else begin
      cnt_nxt = cnt_r - 1'b1;
    end
    if (clr) begin
      sh_nxt   = 10'h3ff;                   // Line returns to idle at once
      left_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_r   <= 10'h3ff;
      left_r <= 4'h0;
      cnt_r  <= '0;
    end else if (clk_en) begin
      sh_r   <= sh_nxt;
      left_r <= left_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign tx   = sh_r[0];
  assign busy = (left_r != 4'h0);

endmodule // mhl_uart_tx

// *** verification/meter_host_link_control_tb.sv ***
// Self-checking bench for the host link control block.
// Assumes shortened time-out and baud parameters.
`timescale 1ns/10ps
`define CHK(nm, exp, act) begin check_count++; if ((act) !== (exp)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, exp, act); end end
module meter_host_link_control_tb;
  localparam int TO = 200;
  localparam int DV_S = 16;
  localparam int DV_F = 8;
  logic clk, rst, clk_en, hw_reset_n, link_purge_n, baud_sel, pulse_init, rx, tx;
  logic data_ready_n, data_fresh, pulse_polarity, cmd_valid, reg_wr, reg_rd;
  logic [2:0]  metering_equation_select;
  logic [31:0] cmd_data, reg_wdata, reg_rdata;
  logic [7:0]  general_io_pin_i, general_io_pin_o, general_io_pin_oe, reg_addr;
  int errors, check_count, cycles, cmd_cnt;

  mhl_top #(.RX_TIMEOUT_CYC(TO), .BAUD_DIV_SLOW(DV_S), .BAUD_DIV_FAST(DV_F),
    .CMD_BYTES(4)) mhl_top_i (.clk(clk), .rst(rst), .clk_en(clk_en),
    .hw_reset_n(hw_reset_n), .link_purge_n(link_purge_n), .baud_sel(baud_sel),
    .pulse_init(pulse_init), .rx(rx), .tx(tx), .data_ready_n(data_ready_n),
    .data_fresh(data_fresh), .metering_equation_select(metering_equation_select),
    .pulse_polarity(pulse_polarity), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .general_io_pin_i(general_io_pin_i), .general_io_pin_o(general_io_pin_o),
    .general_io_pin_oe(general_io_pin_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  mhl_host_model mhl_host_model_i (.clk(clk), .rx(rx));

  // ---------------------------------------------------------------
  // Clock, watchdog, command counter
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cmd_valid === 1'b1) cmd_cnt++;
    if (cycles == 10000) begin
      errors++;
      end_sim;
    end
  end

  // ---------------------------------------------------------------
  // Register port tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic set_equ(input logic [2:0] c);
    wr(mhl_pkg::ADDR_CONFIG, {24'h0, c, 5'h01});
    `CHK("equ", c, metering_equation_select)
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    rd(mhl_pkg::ADDR_CONFIG, d);
    `CHK("config", 32'h0000_00a1, d)
    rd(mhl_pkg::ADDR_STATUS, d);
    `CHK("uninit", 1'b1, d[1])
    rd(8'h1c, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("polarity", 1'b1, pulse_polarity)
    $display("t_reset done");
  endtask
  task automatic t_equ;
    for (int c = 0; c < 8; c++) set_equ(c[2:0]);
    set_equ(mhl_pkg::EQU_GND_3W);
    set_equ(mhl_pkg::EQU_DELTA_4W);
    set_equ(mhl_pkg::EQU_STAR_4W);
    $display("t_equ done");
  endtask
  // Fresh data pulls the pin low; host reads it and clears it
  task automatic t_ready;
    logic [31:0] d;
    @(posedge clk);
    data_fresh <= 1'b1;
    clk_en <= 1'b0;
    @(posedge clk);
    clk_en <= 1'b1;
    #1;
    `CHK("frozen", 1'b1, data_ready_n)
    @(posedge clk);
    data_fresh <= 1'b0;
    #1;
    `CHK("ready_n", 1'b0, data_ready_n)
    rd(mhl_pkg::ADDR_STATUS, d);
    `CHK("ready", 1'b1, d[0])
    wr(mhl_pkg::ADDR_STATUS, 32'h1);
    @(posedge clk);
    #1;
    `CHK("ready_n clr", 1'b1, data_ready_n)
    $display("t_ready done");
  endtask
  // Full command, a stray partial one, time-out, then a clean one
  task automatic t_rx;
    logic [31:0] d;
    int n0;
    wr(mhl_pkg::ADDR_STATUS, 32'h2);
    mhl_host_model_i.send_cmd(32'hc3a5_0f81, 4, DV_F);
    repeat (4) @(posedge clk);
    #1;
    `CHK("cmd", 32'hc3a5_0f81, cmd_data)
    n0 = cmd_cnt;
    mhl_host_model_i.send_cmd(32'h1122_3344, 2, DV_F);
    repeat (20) @(posedge clk);
    rd(mhl_pkg::ADDR_STATUS, d);
    `CHK("uninit early", 1'b0, d[1])
    repeat (TO + 10) @(posedge clk);
    rd(mhl_pkg::ADDR_STATUS, d);
    `CHK("uninit set", 1'b1, d[1])
    `CHK("no cmd", n0, cmd_cnt)
    rd(mhl_pkg::ADDR_STATUS, d);
    `CHK("uninit held", 1'b1, d[1])
    mhl_host_model_i.send_cmd(32'h0a0b_0c0d, 4, DV_F);
    repeat (4) @(posedge clk);
    #1;
    `CHK("cmd aligned", 32'h0a0b_0c0d, cmd_data)
    $display("t_rx done");
  endtask
  // Purge mid-command and switch to the slow rate
  task automatic t_purge;
    mhl_host_model_i.send_cmd(32'hdead_beef, 2, DV_F);
    @(posedge clk);
    link_purge_n <= 1'b0;
    baud_sel <= 1'b0;
    repeat (3) @(posedge clk);
    link_purge_n <= 1'b1;
    repeat (2) @(posedge clk);
    mhl_host_model_i.send_cmd(32'h5a69_7788, 4, DV_S);
    repeat (4) @(posedge clk);
    #1;
    `CHK("cmd purged", 32'h5a69_7788, cmd_data)
    `CHK("equ kept", 3'h5, metering_equation_select)
    $display("t_purge done");
  endtask
  // Pins, transmit start, then a hardware reset with a new strap
  task automatic t_hwreset;
    logic [31:0] d;
    wr(mhl_pkg::ADDR_GIO_DIR, 32'hff);
    wr(mhl_pkg::ADDR_GIO_OUT, 32'ha5);
    `CHK("gio oe", 8'hff, general_io_pin_oe)
    `CHK("gio out", 8'ha5, general_io_pin_o)
    rd(mhl_pkg::ADDR_GIO_IN, d);
    `CHK("gio in", 8'h3c, d[7:0])
    wr(mhl_pkg::ADDR_TXDATA, 32'h5a);
    rd(mhl_pkg::ADDR_STATUS, d);
    `CHK("tx busy", 1'b1, d[2])
    `CHK("tx start", 1'b0, tx)
    wr(mhl_pkg::ADDR_CONFIG, 32'h41);
    @(posedge clk);
    hw_reset_n <= 1'b0;
    pulse_init <= 1'b0;
    @(posedge clk);
    hw_reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("equ rst", 3'h5, metering_equation_select)
    `CHK("gio oe rst", 8'h00, general_io_pin_oe)
    `CHK("tx rst", 1'b1, tx)
    `CHK("polarity", 1'b0, pulse_polarity)
    $display("t_hwreset done");
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    hw_reset_n = 1'b1;
    link_purge_n = 1'b1;
    baud_sel = 1'b1;
    pulse_init = 1'b1;
    data_fresh = 1'b0;
    general_io_pin_i = 8'h3c;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_equ;
    t_ready;
    t_rx;
    t_purge;
    t_hwreset;
    end_sim;
  end
endmodule // meter_host_link_control_tb

// *** verification/mhl_chk.sv ***
// Port checker for the host link control block.
// Assumes one clock domain; bound into every mhl_top.
`timescale 1ns/10ps
module mhl_chk #(
  parameter int CMD_BYTES = 4
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   clk_en,
  input wire logic                   hw_reset_n,
  input wire logic                   link_purge_n,
  input wire logic                   pulse_init,
  input wire logic                   tx,
  input wire logic                   data_ready_n,
  input wire logic                   data_fresh,
  input wire logic [2:0]             metering_equation_select,
  input wire logic                   pulse_polarity,
  input wire logic                   cmd_valid,
  input wire logic [8*CMD_BYTES-1:0] cmd_data,
  input wire logic [7:0]             general_io_pin_o,
  input wire logic [7:0]             general_io_pin_oe,
  input wire logic [7:0]             reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata
);
  logic rst_any_r;
  logic rst_any_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !hw_reset_n);

  // Remember reset so the strap capture edge can be told apart
  always_comb begin
    rst_any_nxt = rst || !hw_reset_n;
  end
  always_ff @(posedge clk) begin
    rst_any_r <= rst_any_nxt;
  end

  AST_EQU_WRITE: assert property (
    clk_en && reg_wr && reg_addr == mhl_pkg::ADDR_CONFIG
    |=> metering_equation_select == $past(reg_wdata[7:5]))
    else $error("equation select not taken from config write");
  AST_READY_FALL: assert property (
    $fell(data_ready_n) |-> $past(data_fresh) || $past(reg_wr))
    else $error("data ready pin fell without fresh data");
  AST_HW_RESET: assert property (disable iff (rst)
    !hw_reset_n && clk_en |=> tx && data_ready_n && !cmd_valid
    && metering_equation_select == 3'h5 && general_io_pin_oe == 8'h00)
    else $error("hardware reset pin did not reset outputs");
  AST_PURGE_IDLE: assert property (
    !link_purge_n [*3] |-> tx && !cmd_valid)
    else $error("link active while purge held low");
  AST_PURGE_KEEPS: assert property (
    !link_purge_n && !reg_wr && !rst_any_r |=> $stable(metering_equation_select)
    && $stable(pulse_polarity) && $stable(general_io_pin_oe))
    else $error("purge disturbed metering settings");
  AST_CMD_HOLD: assert property (
    !cmd_valid && !rst_any_r |-> $stable(cmd_data))
    else $error("command output moved without a command");
  AST_GIO_DIR: assert property (
    clk_en && reg_wr && reg_addr == mhl_pkg::ADDR_GIO_DIR
    |=> general_io_pin_oe == $past(reg_wdata[7:0]))
    else $error("pin direction not written");
  AST_GIO_OUT: assert property (
    clk_en && reg_wr && reg_addr == mhl_pkg::ADDR_GIO_OUT
    |=> general_io_pin_o == $past(reg_wdata[7:0]))
    else $error("pin output not written");
  AST_RDATA_IDLE: assert property (
    clk_en && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_STRAP: assert property (
    rst_any_r && clk_en |=> pulse_polarity == $past(pulse_init))
    else $error("polarity strap not captured");

  COV_CMD: cover property (cmd_valid);
  COV_READY: cover property ($fell(data_ready_n));
  COV_PURGE: cover property (!link_purge_n ##1 link_purge_n);
  COV_HWRST: cover property (disable iff (rst) !hw_reset_n);
endmodule // mhl_chk

bind mhl_top mhl_chk #(.CMD_BYTES(CMD_BYTES)) mhl_chk_i (.*);

// *** verification/mhl_host_model.sv ***
// Host model: sends bytes on the device receive line.
// Assumes 8N1, LSB first, line idle high between bytes.
`timescale 1ns/10ps
module mhl_host_model (
  input  wire logic clk,
  output logic      rx
);
  initial rx = 1'b1;

  // One frame, every bit held div cycles; nothing added
  task automatic send_byte(input logic [7:0] b, input int div);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx <= frame[i];
      repeat (div - 1) @(posedge clk);
    end
  endtask

  // First n bytes of w, most significant byte first
  task automatic send_cmd(input logic [31:0] w, input int n, input int div);
    for (int i = 0; i < n; i++) begin
      send_byte(w[31-8*i -: 8], div);
    end
  endtask
endmodule // mhl_host_model
